// ### inc/latch_loader_pkg.sv
`default_nettype none
package latch_loader_pkg;
   localparam int WORD_BITS = 24;
   localparam int BYTE_BITS = 8;
   localparam int BYTES_PER_WORD = 3;
   localparam logic [1:0] SEL_REF = 2'h0;
   localparam logic [1:0] SEL_FB = 2'h1;
   localparam logic [1:0] SEL_FUNC = 2'h2;
   localparam logic [1:0] SEL_INIT = 2'h3;
   localparam int SEL_LSB = 0;
   localparam int SEL_MSB = 1;
   // Function word bits, layout of this block
   localparam int FUNC_CNT_RST_BIT = 2;
   localparam int FUNC_PD1_BIT = 3;
   localparam int FUNC_MUX_LSB = 4;
   localparam int FUNC_MUX_MSB = 6;
   localparam int FUNC_CP_TRI_BIT = 11;
   localparam logic [2:0] MUX_LOCK = 3'h1;
   localparam logic [WORD_BITS-1:0] LATCH_RESET = 24'h000000;
   localparam int SYS_CLK_MHZ = 50;
   localparam int SCLK_MAX_MHZ = 20;
   // Host makes the serial clock by a divider; half period in system clocks
   localparam int SCLK_MIN_PERIOD_CYC = (SYS_CLK_MHZ + SCLK_MAX_MHZ - 1) / SCLK_MAX_MHZ;
   localparam int SCLK_HALF_CYC = 2 * ((SCLK_MIN_PERIOD_CYC + 1) / 2);
   localparam int HALF_W = 4;
   // Link pin positions in the device synchroniser bank
   localparam int PIN_SCLK = 0;
   localparam int PIN_DATA = 1;
   localparam int PIN_STROBE = 2;
   localparam int PIN_COUNT = 3;
   // Idle pin levels: strobe high, clock and data low
   localparam logic [PIN_COUNT-1:0] PIN_IDLE = 3'h4;
endpackage
`default_nettype wire

// ### inc/latch_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface latch_link_if;
   logic sclk;
   logic sdata;
   logic load_strobe;
   logic power_down_b;
   logic multiplexed_status_out;
   modport device (input sclk, input sdata, input load_strobe, input power_down_b,
      output multiplexed_status_out);
   modport host (output sclk, output sdata, output load_strobe, output power_down_b,
      input multiplexed_status_out);
endinterface
`default_nettype wire

// ### core/latch_loader_device.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - shift data in on each serial rising edge
// - strobe rise moves last 24 bits
// - host serial clock at most 20 MHz
// - host sends one 24-bit word, three bytes
// - host lowers strobe before first bit
// - host raises strobe after last byte
// - host uses phase zero, data set before rise
// - host writes init, function, ref, feedback
// - divider value one is accepted
// - power-down input from host output
// - lock status on multiplexed output, polled
// - low two bits select target latch
// - power-down immediate, latches kept
// - init load sets function, pulses reset
module latch_loader_device (
   input wire logic clk_sys,
   input wire logic rst_b,
   latch_link_if.device link,
   input wire logic lock_in,
   output logic [latch_loader_pkg::WORD_BITS-1:0] ref_div_q,
   output logic [latch_loader_pkg::WORD_BITS-1:0] fb_div_q,
   output logic [latch_loader_pkg::WORD_BITS-1:0] func_q,
   output logic counter_reset_pulse,
   output logic cp_tristate,
   output logic powered_down
);
   import latch_loader_pkg::*;

   // Link pins, raw and after two flops
   logic [PIN_COUNT-1:0] pin_raw;
   logic [PIN_COUNT-1:0] pin_sync;
   logic sclk_prev_q;
   logic strobe_prev_q;
   logic sclk_rise;
   logic strobe_rise;
   logic data_bit;

   // Input shift register and latch decode
   logic [WORD_BITS-1:0] shift_q;
   logic [1:0] sel_bits;
   logic load_ref;
   logic load_fb;
   logic load_func;
   logic load_init;

   // Internal reset and pump control
   logic init_pulse_q;
   logic arm_fb_q;
   logic fb_pulse_q;
   logic count_hold;
   logic pump_off;

   // Status output select
   logic [2:0] mux_sel;
   logic status_out;

   assign pin_raw[PIN_SCLK] = link.sclk;
   assign pin_raw[PIN_DATA] = link.sdata;
   assign pin_raw[PIN_STROBE] = link.load_strobe;

   // Two flops per clock, data and strobe pin before any logic reads it; power_down_b is not in the bank
   genvar gi;
   generate
      for (gi = 0; gi < PIN_COUNT; gi++) begin : g_pin_sync
         logic meta_q;
         logic sync_q;
         always_ff @(posedge clk_sys or negedge rst_b) begin
            if (!rst_b) begin
               meta_q <= PIN_IDLE[gi];
               sync_q <= PIN_IDLE[gi];
            end else begin
               meta_q <= pin_raw[gi];
               sync_q <= meta_q;
            end
         end
         assign pin_sync[gi] = sync_q;
      end
   endgenerate

   // Edge history resets to the idle level: no false edge after reset
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         sclk_prev_q <= PIN_IDLE[PIN_SCLK];
      end else begin
         sclk_prev_q <= pin_sync[PIN_SCLK];
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         strobe_prev_q <= PIN_IDLE[PIN_STROBE];
      end else begin
         strobe_prev_q <= pin_sync[PIN_STROBE];
      end
   end

   assign sclk_rise = pin_sync[PIN_SCLK] & ~sclk_prev_q;
   assign strobe_rise = pin_sync[PIN_STROBE] & ~strobe_prev_q;
   assign data_bit = pin_sync[PIN_DATA];

   // MSB first: new bit enters at the bottom
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         shift_q <= LATCH_RESET;
      end else if (sclk_rise) begin
         shift_q <= {shift_q[WORD_BITS-2:0], data_bit};
      end
   end

   assign sel_bits = shift_q[SEL_MSB:SEL_LSB];

   // One load enable per latch, on the strobe rise
   always_comb begin
      load_ref = 1'b0;
      load_fb = 1'b0;
      load_func = 1'b0;
      load_init = 1'b0;
      if (strobe_rise) begin
         if (sel_bits == SEL_REF) begin
            load_ref = 1'b1;
         end else if (sel_bits == SEL_FB) begin
            load_fb = 1'b1;
         end else if (sel_bits == SEL_FUNC) begin
            load_func = 1'b1;
         end else begin
            load_init = 1'b1;
         end
      end
   end

   // Latches load even when powered down, so contents survive
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ref_div_q <= LATCH_RESET;
      end else if (load_ref) begin
         ref_div_q <= shift_q;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         fb_div_q <= LATCH_RESET;
      end else if (load_fb) begin
         fb_div_q <= shift_q;
      end
   end

   // Init word carries the function settings as well
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         func_q <= LATCH_RESET;
      end else if (load_func || load_init) begin
         func_q <= shift_q;
      end
   end

   // Init load pulses the internal counter reset
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         init_pulse_q <= 1'b0;
      end else begin
         init_pulse_q <= load_init;
      end
   end

   // Init arms one more pulse for the next feedback load
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         arm_fb_q <= 1'b0;
      end else if (load_init) begin
         arm_fb_q <= 1'b1;
      end else if (load_fb) begin
         arm_fb_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         fb_pulse_q <= 1'b0;
      end else begin
         fb_pulse_q <= load_fb && arm_fb_q;
      end
   end

   assign count_hold = func_q[FUNC_CNT_RST_BIT];
   assign counter_reset_pulse = init_pulse_q | fb_pulse_q | count_hold;

   // Power-down acts straight off the pin, no clock involved
   assign powered_down = ~link.power_down_b;

   // Pump stays off from the init load until the first feedback load
   always_comb begin
      pump_off = powered_down | counter_reset_pulse;
      if (func_q[FUNC_CP_TRI_BIT] || arm_fb_q) begin
         pump_off = 1'b1;
      end
   end
   assign cp_tristate = pump_off;

   assign mux_sel = func_q[FUNC_MUX_MSB:FUNC_MUX_LSB];

   always_comb begin
      status_out = 1'b0;
      if (mux_sel == MUX_LOCK) begin
         status_out = lock_in;
      end
   end
   assign link.multiplexed_status_out = status_out;
endmodule
`default_nettype wire

// ### core/latch_loader_host.sv
`timescale 1ns/1ps
`default_nettype none
module latch_loader_host (
   input wire logic clk_sys,
   input wire logic rst_b,
   latch_link_if.host link,
   input wire logic req_valid,
   output logic req_ready,
   input wire logic [latch_loader_pkg::WORD_BITS-1:0] req_word,
   input wire logic power_down_req,
   output logic lock_seen_q
);
   import latch_loader_pkg::*;

   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_LOW = 2'h1,
      ST_HIGH = 2'h2,
      ST_DONE = 2'h3
   } host_state_t;

   host_state_t state_q;
   logic [WORD_BITS-1:0] word_q;
   logic [4:0] bit_q;
   logic [HALF_W-1:0] div_q;
   logic sclk_q, le_q, pd_b_q;
   logic [1:0] lock_s;
   logic tick;

   assign tick = div_q == HALF_W'(SCLK_HALF_CYC - 1);
   assign req_ready = state_q == ST_IDLE;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         div_q <= '0;
      end else if (state_q == ST_IDLE || tick) begin
         div_q <= '0;
      end else begin
         div_q <= div_q + HALF_W'(1);
      end
   end

   // Rising edge mid-bit: data set while clock low (phase zero)
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= ST_IDLE;
         word_q <= LATCH_RESET;
         bit_q <= 5'h0;
         sclk_q <= 1'b0;
         le_q <= 1'b1;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (req_valid) begin
                  word_q <= req_word;
                  bit_q <= 5'(WORD_BITS - 1);
                  le_q <= 1'b0;
                  state_q <= ST_LOW;
               end
            end
            ST_LOW: begin
               if (tick) begin
                  sclk_q <= 1'b1;
                  state_q <= ST_HIGH;
               end
            end
            ST_HIGH: begin
               if (tick) begin
                  sclk_q <= 1'b0;
                  word_q <= {word_q[WORD_BITS-2:0], 1'b0};
                  if (bit_q == 5'h0) begin
                     state_q <= ST_DONE;
                  end else begin
                     bit_q <= bit_q - 5'h1;
                     state_q <= ST_LOW;
                  end
               end
            end
            ST_DONE: begin
               if (tick) begin
                  le_q <= 1'b1;
                  state_q <= ST_IDLE;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         pd_b_q <= 1'b1;
         lock_s <= 2'h0;
         lock_seen_q <= 1'b0;
      end else begin
         pd_b_q <= ~power_down_req;
         lock_s <= {lock_s[0], link.multiplexed_status_out};
         lock_seen_q <= lock_s[1];
      end
   end

   assign link.sclk = sclk_q;
   assign link.sdata = word_q[WORD_BITS-1];
   assign link.load_strobe = le_q;
   assign link.power_down_b = pd_b_q;
endmodule
`default_nettype wire

// ### test/latch_link_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module latch_link_assertions (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic sclk,
   input wire logic sdata,
   input wire logic load_strobe,
   input wire logic power_down_b,
   input wire logic multiplexed_status_out
);
   logic [4:0] bits_q;
   logic sclk_prev_q;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         sclk_prev_q <= 1'b0;
      end else begin
         sclk_prev_q <= sclk;
      end
   end
   // Serial rises inside the current frame
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         bits_q <= 5'h00;
      end else if (load_strobe) begin
         bits_q <= 5'h00;
      end else if (sclk && !sclk_prev_q) begin
         bits_q <= bits_q + 5'h01;
      end
   end
   idle_clock_a: assert property (load_strobe |-> !sclk)
      else $error("serial clock outside frame");
   lead_in_a: assert property ($fell(load_strobe) |-> !sclk ##1 !sclk)
      else $error("clock too soon after strobe fall");
   high_phase_a: assert property ($rose(sclk) |=> sclk)
      else $error("serial high phase short");
   low_phase_a: assert property ($fell(sclk) |=> !sclk)
      else $error("serial low phase short");
   data_hold_a: assert property ($rose(sclk) |-> $stable(sdata))
      else $error("data moved at rising edge");
   word_bits_a: assert property ($rose(load_strobe) |-> bits_q == 5'h18)
      else $error("frame not 24 bits");
   strobe_gap_a: assert property ($rose(load_strobe) |=> load_strobe)
      else $error("strobe high too short");
   frame_end_a: assert property ($fell(load_strobe) |-> ##[2:200] $rose(load_strobe))
      else $error("frame never closed");
   cover property ($rose(load_strobe));
   cover property ($rose(multiplexed_status_out));
   cover property ($fell(power_down_b));
endmodule
`default_nettype wire

// ### test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import latch_loader_pkg::*;
   logic clk_sys, rst_b, lock_in, req_valid, req_ready, power_down_req, lock_seen_q;
   logic counter_reset_pulse, cp_tristate, powered_down, pulse_seen;
   logic [WORD_BITS-1:0] req_word, ref_div_q, fb_div_q, func_q;
   int fails, samples_checked;
   latch_link_if link ();
   latch_loader_host latch_loader_host_i (.clk_sys(clk_sys), .rst_b(rst_b), .link(link),
      .req_valid(req_valid), .req_ready(req_ready), .req_word(req_word),
      .power_down_req(power_down_req), .lock_seen_q(lock_seen_q));
   latch_loader_device latch_loader_device_i (.clk_sys(clk_sys), .rst_b(rst_b), .link(link),
      .lock_in(lock_in), .ref_div_q(ref_div_q), .fb_div_q(fb_div_q), .func_q(func_q),
      .counter_reset_pulse(counter_reset_pulse), .cp_tristate(cp_tristate),
      .powered_down(powered_down));
   latch_link_assertions latch_link_assertions_i (.clk_sys(clk_sys), .rst_b(rst_b),
      .sclk(link.sclk), .sdata(link.sdata), .load_strobe(link.load_strobe),
      .power_down_b(link.power_down_b), .multiplexed_status_out(link.multiplexed_status_out));
   task automatic test_done();
      if (fails == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("unexpected %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic chk_bit(input string name, input logic exp, input logic got);
      chk(name, {23'h0, exp}, {23'h0, got});
   endtask
   task automatic wait_ready();
      int n;
      n = 0;
      while (req_ready !== 1'b1) begin
         @(negedge clk_sys);
         n++;
         if (n > 400) begin
            fails++;
            test_done();
         end
      end
   endtask
   task automatic write_word(input logic [23:0] w);
      wait_ready();
      req_valid = 1'b1;
      req_word = w;
      @(negedge clk_sys);
      req_valid = 1'b0;
      wait_ready();
      repeat (6) @(negedge clk_sys);
   endtask
   task automatic settle();
      repeat (6) @(negedge clk_sys);
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   always @(negedge clk_sys) begin
      if (counter_reset_pulse === 1'b1) pulse_seen = 1'b1;
   end
   initial begin
      rst_b = 1'b0;
      lock_in = 1'b0;
      req_valid = 1'b0;
      req_word = 24'h000000;
      power_down_req = 1'b0;
      pulse_seen = 1'b0;
      fails = 0;
      samples_checked = 0;
      repeat (2) @(negedge clk_sys);
      rst_b = 1'b1;
      chk("ref_div_q", LATCH_RESET, ref_div_q);
      write_word(24'h000803);
      chk("func_q", 24'h000803, func_q);
      chk_bit("pulse_seen", 1'b1, pulse_seen);
      chk_bit("cp_tristate", 1'b1, cp_tristate);
      write_word(24'h000012);
      chk("func_q", 24'h000012, func_q);
      chk_bit("cp_tristate", 1'b1, cp_tristate);
      write_word(24'h000004);
      chk("ref_div_q", 24'h000004, ref_div_q);
      pulse_seen = 1'b0;
      write_word(24'h000005);
      chk("fb_div_q", 24'h000005, fb_div_q);
      chk_bit("pulse_seen", 1'b1, pulse_seen);
      chk("func_q", 24'h000012, func_q);
      chk_bit("cp_tristate", 1'b0, cp_tristate);
      write_word(24'h000016);
      chk_bit("counter_reset_pulse", 1'b1, counter_reset_pulse);
      chk_bit("cp_tristate", 1'b1, cp_tristate);
      write_word(24'h000012);
      chk_bit("counter_reset_pulse", 1'b0, counter_reset_pulse);
      lock_in = 1'b1;
      settle();
      chk_bit("lock_seen_q", 1'b1, lock_seen_q);
      lock_in = 1'b0;
      settle();
      chk_bit("lock_seen_q", 1'b0, lock_seen_q);
      power_down_req = 1'b1;
      settle();
      chk_bit("powered_down", 1'b1, powered_down);
      chk_bit("cp_tristate", 1'b1, cp_tristate);
      chk("ref_div_q", 24'h000004, ref_div_q);
      power_down_req = 1'b0;
      settle();
      chk_bit("powered_down", 1'b0, powered_down);
      write_word(24'ha5c3f0);
      chk("ref_div_q", 24'ha5c3f0, ref_div_q);
      chk("fb_div_q", 24'h000005, fb_div_q);
      write_word(24'h000002);
      lock_in = 1'b1;
      settle();
      chk_bit("lock_seen_q", 1'b0, lock_seen_q);
      test_done();
   end
endmodule
`default_nettype wire
